// File: hdl/mmtr_top.sv
`timescale 1ns/1ps
module mmtr_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [31:0] act_pos,
	input wire logic [31:0] home_pos,
	input wire logic homing_done,
	input wire logic probe_edge_input,
	input wire logic master_speed_reached,
	output logic [31:0] dest_pos,
	output logic dest_valid,
	output logic vel_mode,
	output logic gear_en,
	output logic gear_direct,
	output logic gear_lock,
	output logic target_reached,
	output logic dig_out
);
	import mmtr_pkg::*;

	// ****************************************
	// bus and registers
	// ****************************************
	logic wr_pulse;
	logic rd_pulse;
	logic [7:0] acc_adr;
	logic [31:0] cfg_mode;
	logic [31:0] cfg_target;
	logic [31:0] cfg_offset;
	logic [31:0] cfg_window;
	logic cfg_dual_enc;
	logic cfg_jog;
	logic [7:0] cfg_outmode;
	logic start_req;
	logic [7:0] act_mode;
	logic homed;
	logic [31:0] ref_point;
	logic probe_prev;
	logic invalid;
	logic gear_err;
	logic last_was_jog;
	mmtr_state_t state;

	mmtr_wb_slave u_wb (
		.mclk(mclk),
		.rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_ack_o(wb_ack_o),
		.wr_pulse(wr_pulse),
		.rd_pulse(rd_pulse),
		.acc_adr(acc_adr)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// mode decode used by validation and motion setup
	function automatic logic mode_ok(input logic [7:0] m);
		return (m <= 8'h04) || (m >= 8'h0a && m <= 8'h0e) || (m >= 8'h14 && m <= 8'h18);
	endfunction : mode_ok

	function automatic logic [2:0] base_of(input logic [7:0] m);
		logic [7:0] b;
		b = (m >= 8'h14) ? m - 8'h14 : (m >= 8'h0a) ? m - 8'h0a : m;
		return b[2:0];
	endfunction : base_of

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfg_mode <= mode_rst; // see R02
			cfg_target <= 32'h0000_0000;
			cfg_offset <= offset_rst;
			cfg_window <= window_rst;
			cfg_dual_enc <= 1'b0;
			cfg_jog <= 1'b0;
			cfg_outmode <= 8'h00;
		end else if (wr_pulse) begin
			unique case (acc_adr)
				reg_mode: cfg_mode <= merge(cfg_mode, wb_dat_i, wb_sel_i);
				reg_target: cfg_target <= merge(cfg_target, wb_dat_i, wb_sel_i);
				reg_offset: cfg_offset <= merge(cfg_offset, wb_dat_i, wb_sel_i);
				reg_window: cfg_window <= merge(cfg_window, wb_dat_i, wb_sel_i);
				reg_ctrl: begin
					if (wb_sel_i[0]) begin
						cfg_jog <= wb_dat_i[ctrl_jog];
						cfg_dual_enc <= wb_dat_i[ctrl_dual_enc];
					end
				end
				reg_outmode: begin
					if (wb_sel_i[0]) begin
						cfg_outmode <= wb_dat_i[7:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			start_req <= 1'b0;
		end else begin
			start_req <= wr_pulse && acc_adr == reg_ctrl && wb_sel_i[0] && wb_dat_i[ctrl_start];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd_pulse) begin
			unique case (acc_adr)
				reg_mode: wb_dat_o <= cfg_mode;
				reg_target: wb_dat_o <= cfg_target;
				reg_offset: wb_dat_o <= cfg_offset;
				reg_window: wb_dat_o <= cfg_window;
				reg_ctrl: wb_dat_o <= {29'h0, cfg_dual_enc, cfg_jog, 1'b0};
				reg_status: wb_dat_o <= {22'h0, gear_lock, vel_mode, gear_direct, gear_en, gear_err, invalid,
					state == mmtr_probe, dest_valid, homed, target_reached};
				reg_dest: wb_dat_o <= dest_pos;
				reg_act_mode: wb_dat_o <= {24'h0, act_mode}; // see R14
				reg_outmode: wb_dat_o <= {24'h0, cfg_outmode};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// reference point and probe capture
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			homed <= 1'b0;
			ref_point <= 32'h0000_0000;
		end else if (homing_done) begin
			homed <= 1'b1; // see R03
			ref_point <= home_pos + cfg_offset; // see R17
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			probe_prev <= 1'b0;
		end else begin
			probe_prev <= probe_edge_input;
		end
	end
	wire probe_rise = probe_edge_input && !probe_prev;
	wire probe_fall = !probe_edge_input && probe_prev;
	wire [2:0] act_base = base_of(act_mode);
	wire probe_hit = (act_base == 3'd2) ? probe_rise : probe_fall; // see R06 see R07

	// ****************************************
	// block start and destination
	// ****************************************
	wire [7:0] req_mode = cfg_mode[7:0];
	wire req_gear = req_mode >= 8'h0a;
	wire req_ok = mode_ok(req_mode) && cfg_mode[31:8] == 24'h0;
	wire req_gear_bad = req_gear && cfg_dual_enc; // see R13
	wire [2:0] req_base = base_of(req_mode);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= mmtr_idle;
			act_mode <= 8'h00;
			dest_pos <= 32'h0000_0000;
			dest_valid <= 1'b0;
			vel_mode <= 1'b0;
			gear_en <= 1'b0;
			gear_direct <= 1'b0;
			invalid <= 1'b0;
			gear_err <= 1'b0;
			last_was_jog <= 1'b1;
		end else if (start_req) begin
			invalid <= !req_ok; // see R20
			gear_err <= req_ok && req_gear_bad;
			if (req_ok && !req_gear_bad) begin
				act_mode <= req_mode;
				gear_en <= req_gear; // see R09 see R11
				gear_direct <= req_mode >= 8'h14; // see R11 see R12
				vel_mode <= req_base == 3'd4; // see R08 see R10 see R12
				last_was_jog <= cfg_jog;
				unique case (req_base)
					3'd0: begin
						dest_pos <= ref_point + cfg_target; // see R01
						dest_valid <= 1'b1;
						state <= mmtr_move;
					end
					3'd1: begin
						// see R04 see R05
						dest_pos <= (cfg_jog || last_was_jog) ? act_pos + cfg_target : dest_pos + cfg_target;
						dest_valid <= 1'b1;
						state <= mmtr_move;
					end
					3'd2, 3'd3: begin
						dest_valid <= 1'b0;
						state <= mmtr_probe;
					end
					default: begin
						// velocity keeps the destination untouched, the target is not read
						dest_valid <= 1'b0;
						state <= mmtr_move;
					end
				endcase
			end else begin
				// a refused block must not leave the previous motion running
				dest_valid <= 1'b0;
				vel_mode <= 1'b0;
				gear_en <= 1'b0;
				gear_direct <= 1'b0;
				state <= mmtr_idle;
			end
		end else if (state == mmtr_probe && probe_hit) begin
			dest_pos <= act_pos + cfg_target; // see R18 see R19
			dest_valid <= 1'b1;
			state <= mmtr_move;
		end else if (state == mmtr_move && dest_valid && act_pos == dest_pos) begin
			state <= mmtr_done;
		end
	end

	// ****************************************
	// target reached and gearing lock
	// ****************************************
	wire [31:0] pos_err = act_pos - dest_pos;
	wire [31:0] pos_abs = pos_err[31] ? (~pos_err + 32'h1) : pos_err;
	wire in_window = pos_abs <= cfg_window;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			target_reached <= 1'b0;
		end else if (start_req) begin
			target_reached <= 1'b0; // see R15
		end else if (state == mmtr_move && dest_valid && act_pos == dest_pos) begin
			target_reached <= 1'b1; // see R15
		end else if (!in_window) begin
			target_reached <= 1'b0; // see R15
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gear_lock <= 1'b0;
		end else if (start_req) begin
			gear_lock <= req_ok && !req_gear_bad && req_mode >= 8'h14; // see R11
		end else if (gear_en && master_speed_reached) begin
			gear_lock <= 1'b1; // see R09 see R10
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dig_out <= 1'b0;
		end else begin
			// see R16
			dig_out <= (cfg_outmode == outmode_tgt) ? target_reached :
				(cfg_outmode == outmode_tgt_inv) ? !target_reached : 1'b0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence start_abs_s;
		start_req && req_ok && !req_gear_bad && req_base == 3'd0;
	endsequence

	abs_dest_a: assert property (@(posedge mclk) disable iff (!rst_n)
		start_abs_s |=> dest_pos == $past(ref_point) + $past(cfg_target) && dest_valid) // see R01
		else $error("absolute destination wrong");
	reset_mode_a: assert property (@(posedge mclk) !rst_n |=> cfg_mode == mode_rst) // see R02
		else $error("mode not absolute after reset");
	ref_point_a: assert property (@(posedge mclk) disable iff (!rst_n)
		homing_done |=> homed && ref_point == $past(home_pos) + $past(cfg_offset)) // see R17
		else $error("reference point wrong");
	inval_a: assert property (@(posedge mclk) disable iff (!rst_n)
		start_req && !req_ok |=> invalid && !dest_valid && !vel_mode && !gear_en && state == mmtr_idle) // see R20
		else $error("invalid mode started motion");
	dual_enc_a: assert property (@(posedge mclk) disable iff (!rst_n)
		start_req && req_gear_bad |=> !dest_valid ##0 !gear_lock) // see R13
		else $error("gear allowed with two encoders");
	probe_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
		state == mmtr_probe && probe_hit && !start_req |=> dest_pos == $past(act_pos) + $past(cfg_target)) // see R18
		else $error("probe destination wrong");
	reach_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
		start_req |=> !target_reached) // see R15
		else $error("reached not cleared at start");
	direct_lock_a: assert property (@(posedge mclk) disable iff (!rst_n)
		start_req && req_ok && !req_gear_bad && req_mode >= 8'h14 |=> gear_lock && gear_direct) // see R11
		else $error("direct sync not locked");
	dig_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cfg_outmode == outmode_tgt && $stable(cfg_outmode) |=> dig_out == $past(target_reached)) // see R16
		else $error("digital output not routed");
	vel_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
		start_req && req_ok && !req_gear_bad && req_base == 3'd4 |=> vel_mode && $stable(dest_pos)) // see R08
		else $error("velocity used target");
endmodule : mmtr_top

// File: hdl/mmtr_pkg.sv
//
// Function
// R01: mode 0 destination is configured target relative to the reference point.
// R02: motion mode selection resets to absolute.
// R03: reference point is fixed by a completed homing operation.
// R04: mode 1 after a block: previous destination plus distance, reached or not.
// R05: relative after jogging: measured position plus distance.
// R06: mode 2 captures reference on rising probe edge, then relative move.
// R07: mode 3 captures reference on falling probe edge, then relative move.
// R08: mode 4 runs the block speed profile and ignores the target value.
// R09: modes 10-13 are modes 0-3 with gearing, lock at master speed.
// R10: mode 14 is velocity with gear profile, sync at master speed.
// R11: modes 20-23 are modes 0-3 with gearing, direct lock at block start.
// R12: mode 24 follows gear profile, ignores target, direct sync at start.
// R13: gearing is unavailable when separate motor and position encoders exist.
// R14: motion mode of the executing block is readable.
// R15: target reached sets at destination, clears on next start or window exit.
// R16: target reached routes to a digital output in mode 60 or 160.
// R17: reference point is home position plus signed offset.
// R18: probe destination is captured position plus distance.
// R19: positions, distances and destinations are signed 32-bit.
// R20: unknown mode codes are invalid and start no motion.
package mmtr_pkg;
	// ****************************************
	// register map (word offsets are byte addresses)
	// ****************************************
	localparam logic [7:0] reg_mode = 8'h00;
	localparam logic [7:0] reg_target = 8'h04;
	localparam logic [7:0] reg_offset = 8'h08;
	localparam logic [7:0] reg_window = 8'h0c;
	localparam logic [7:0] reg_ctrl = 8'h10;
	localparam logic [7:0] reg_status = 8'h14;
	localparam logic [7:0] reg_dest = 8'h18;
	localparam logic [7:0] reg_act_mode = 8'h1c;
	localparam logic [7:0] reg_outmode = 8'h20;
	localparam logic [31:0] mode_rst = 32'h0000_0000;
	localparam logic [31:0] offset_rst = 32'h0000_0000;
	localparam logic [31:0] window_rst = 32'h0000_0100;
	localparam logic [7:0] outmode_tgt = 8'h3c;
	localparam logic [7:0] outmode_tgt_inv = 8'ha0;
	// ctrl bits
	localparam int ctrl_start = 0;
	localparam int ctrl_jog = 1;
	localparam int ctrl_dual_enc = 2;
	// status bits
	localparam int st_reached = 0;
	localparam int st_homed = 1;
	localparam int st_busy = 2;
	localparam int st_wait_probe = 3;
	localparam int st_invalid = 4;
	localparam int st_gear_err = 5;
	localparam int st_gear = 6;
	localparam int st_direct = 7;
	localparam int st_vel = 8;
	localparam int st_locked = 9;
	typedef enum logic [1:0] {
		mmtr_idle = 2'b00,
		mmtr_probe = 2'b01,
		mmtr_move = 2'b11,
		mmtr_done = 2'b10
	} mmtr_state_t;
endpackage : mmtr_pkg

// File: hdl/mmtr_wb_slave.sv
`timescale 1ns/1ps
// classic wishbone handshake: one-cycle ack, one request per cycle pair
module mmtr_wb_slave (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	output logic wb_ack_o,
	output logic wr_pulse,
	output logic rd_pulse,
	output logic [7:0] acc_adr
);
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end
	// a write is applied on the ack edge, when the master samples it; a read is latched one edge earlier, on the request
	assign wr_pulse = wb_ack_o && wb_we_i;
	assign rd_pulse = req && !wb_we_i;
	assign acc_adr = wb_adr_i;
endmodule : mmtr_wb_slave

// File: verif/mmtr_ramp_model.sv
`timescale 1ns/1ps
// ****************************************
// drive ramp model: steps toward the destination, reports master speed
// ****************************************
module mmtr_ramp_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [31:0] dest_pos,
	input wire logic dest_valid,
	input wire logic gear_en,
	output logic [31:0] act_pos,
	output logic master_speed_reached
);
	logic [1:0] spin;
	logic signed [31:0] gap;
	assign gap = dest_pos - act_pos;
	// coarse steps so that a move spans many cycles and the window is crossed
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			act_pos <= 32'h0;
		end else if (run && dest_valid) begin
			act_pos <= (gap > 32'sh10) ? act_pos + 32'h10 : (gap < -32'sh10) ? act_pos - 32'h10 : dest_pos;
		end
	end
	// master speed only some cycles after gearing engages, never at once
	always_ff @(posedge mclk) begin
		if (!rst_n || !gear_en) begin
			spin <= 2'h0;
			master_speed_reached <= 1'b0;
		end else begin
			spin <= (spin == 2'h3) ? spin : spin + 2'h1;
			master_speed_reached <= (spin == 2'h3);
		end
	end
endmodule : mmtr_ramp_model

// File: verif/motion_mode_target_resolver_bench.sv
`timescale 1ns/1ps
module motion_mode_target_resolver_bench;
	import mmtr_pkg::*;
	typedef struct {logic [31:0] mode; logic [31:0] tgt; logic [31:0] dest; logic [4:0] fl;} mmtr_row_t;
	// fl: valid, vel, gear, direct, lock
	mmtr_row_t rows [14] = '{'{32'h0, 32'h32, 32'h424, 5'h10}, '{32'h1, 32'h64, 32'h488, 5'h10},
		'{32'h1, 32'hffffffc4, 32'h44c, 5'h10}, '{32'ha, 32'h0, 32'h3f2, 5'h14}, '{32'h14, 32'h2, 32'h3f4, 5'h17},
		'{32'hb, 32'h8, 32'h3fc, 5'h15}, '{32'h15, 32'h1, 32'h3fd, 5'h17}, '{32'he, 32'h5, 32'h0, 5'h0d},
		'{32'h18, 32'h5, 32'h0, 5'h0f}, '{32'h4, 32'h5, 32'h0, 5'h08}, '{32'h5, 32'h5, 32'h0, 5'h00},
		'{32'hf, 32'h5, 32'h0, 5'h00}, '{32'h19, 32'h5, 32'h0, 5'h00}, '{32'h100, 32'h5, 32'h0, 5'h00}};
	logic mclk, rst_n, cyc, stb, we, homing_done, probe, run, ack, msr;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, act_pos, home_pos, dest_pos, q;
	logic dest_valid, vel_mode, gear_en, gear_direct, gear_lock, target_reached, dig_out;
	int mismatches, checks;
	mmtr_top u_mmtr_top (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .act_pos(act_pos),
		.home_pos(home_pos), .homing_done(homing_done), .probe_edge_input(probe), .master_speed_reached(msr),
		.dest_pos(dest_pos), .dest_valid(dest_valid), .vel_mode(vel_mode), .gear_en(gear_en),
		.gear_direct(gear_direct), .gear_lock(gear_lock), .target_reached(target_reached), .dig_out(dig_out));
	mmtr_ramp_model u_mmtr_ramp_model (.mclk(mclk), .rst_n(rst_n), .run(run), .dest_pos(dest_pos),
		.dest_valid(dest_valid), .gear_en(gear_en), .act_pos(act_pos), .master_speed_reached(msr));
	// ****************************************
	// tasks
	// ****************************************
	task automatic cw(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : cw
	task automatic cb(input string nm, input logic e, input logic g);
		cw(nm, {31'h0, e}, {31'h0, g});
	endtask : cb
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	// one classic cycle; the request stands until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge mclk);
		{cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
		@(posedge mclk);
		while (ack !== 1'b1 && n < 100) begin
			n++;
			@(posedge mclk);
		end
		r = rdat;
		{cyc, stb} <= 2'b00;
		if (n >= 100) begin
			cb("ack", 1'b1, 1'b0);
		end
	endtask : wb
	task automatic start_blk(input logic [31:0] m, input logic [31:0] t, input logic [31:0] c);
		wb(1'b1, reg_mode, m, q);
		wb(1'b1, reg_target, t, q);
		wb(1'b1, reg_ctrl, c | 32'h1, q);
		repeat (2) @(posedge mclk);
		#1;
	endtask : start_blk
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		#2000000;
		mismatches++;
		give_verdict();
	end
	initial begin
		{rst_n, cyc, stb, we, homing_done, probe, run, adr, wdat, home_pos} = '0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		wb(1'b0, reg_mode, 32'h0, q);
		cw("mode", mode_rst, q);
		wb(1'b0, reg_window, 32'h0, q);
		cw("window", window_rst, q);
		cb("reached", 1'b0, target_reached);
		wb(1'b1, reg_offset, 32'ha, q);
		home_pos <= 32'h3e8;
		homing_done <= 1'b1;
		@(posedge mclk);
		homing_done <= 1'b0;
		for (int i = 0; i < 14; i++) begin
			start_blk(rows[i].mode, rows[i].tgt, 32'h0);
			cb("dest_valid", rows[i].fl[4], dest_valid);
			cb("vel_mode", rows[i].fl[3], vel_mode);
			cb("gear_en", rows[i].fl[2], gear_en);
			cb("gear_direct", rows[i].fl[1], gear_direct);
			cb("gear_lock", rows[i].fl[0], gear_lock);
			if (rows[i].fl[4]) begin
				cw("dest_pos", rows[i].dest, dest_pos);
			end
			if (rows[i].fl[4] | rows[i].fl[3]) begin
				wb(1'b0, reg_act_mode, 32'h0, q);
				cw("act_mode", rows[i].mode, q);
			end
		end
		// a full move to the target, then the output routing in both senses
		wb(1'b1, reg_outmode, {24'h0, outmode_tgt}, q);
		run <= 1'b1;
		start_blk(32'h0, 32'h32, 32'h0);
		for (int n = 0; n < 500 && target_reached !== 1'b1; n++) begin
			@(posedge mclk);
		end
		#1;
		cb("reached", 1'b1, target_reached);
		cw("act_pos", 32'h424, act_pos);
		cb("dig_out", 1'b1, dig_out);
		wb(1'b1, reg_outmode, {24'h0, outmode_tgt_inv}, q);
		run <= 1'b0;
		repeat (3) @(posedge mclk);
		cb("dig_out", 1'b0, dig_out);
		start_blk(32'h1, 32'h5, 32'h2);
		cw("dest_pos", 32'h429, dest_pos);
		cb("reached", 1'b0, target_reached);
		for (int m = 2; m < 4; m++) begin
			start_blk(m, 32'h7, 32'h0);
			cb("dest_valid", 1'b0, dest_valid);
			probe <= (m == 2);
			repeat (3) @(posedge mclk);
			#1;
			cb("dest_valid", 1'b1, dest_valid);
			cw("dest_pos", 32'h42b, dest_pos);
		end
		start_blk(32'ha, 32'h0, 32'h4);
		cb("gear_en", 1'b0, gear_en);
		wb(1'b0, reg_status, 32'h0, q);
		cb("gear_err", 1'b1, q[st_gear_err]);
		wb(1'b0, 8'h40, 32'h0, q);
		cw("unmapped", 32'h0, q);
		// a reset in mid-run must restore the defaults and drop the routed output
		cb("dig_out", 1'b1, dig_out);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		cb("dig_out", 1'b0, dig_out);
		cb("gear_lock", 1'b0, gear_lock);
		wb(1'b0, reg_mode, 32'h0, q);
		cw("mode", mode_rst, q);
		wb(1'b0, reg_ctrl, 32'h0, q);
		cw("ctrl", 32'h0, q);
		give_verdict();
	end
endmodule : motion_mode_target_resolver_bench
